// [cpu_bus_model.sv]
// CPU side of the register port: word or byte writes and byte reads
module cpu_bus_model (
    // Clock
    input wire logic clk,
    // Register port
    output logic [15:0] addr,
    output logic wr,
    output logic word,
    output logic [15:0] wdata,
    output logic rd,
    input wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        addr = 16'h0000;
        wr = 1'b0;
        word = 1'b0;
        wdata = 16'h0000;
        rd = 1'b0;
    end
    task automatic put(input logic [15:0] a, input logic [15:0] d,
                       input logic w);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        word <= w;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        // Released lines must not look like a held request
        addr <= ~a;
        wdata <= ~d;
    endtask : put
    task automatic get(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1 d = rdata;
    endtask : get
endmodule : cpu_bus_model

// [watchdog_interval_timer.sv]
// Supervisory timer: counter, control registers, reset and interrupt logic
// Operation
// - 8-bit readable writable counter advances on selected tap while running
// - Rollover from ff to 00 sets overflow flag
// - Counter zero on reset and held at zero while not running
// - Three select bits pick divide 2..4096 taps, code 0 at reset
// - Mode bit 6: 0 interval interrupt, 1 chip reset on overflow
// - Software clears overflow flag only by writing 0 after reading it as 1
// - Control bits 7..5 clear on reset and standby; 2..0 only on reset
// - Reset control bits 7..6 initialised only by external init pin
// - Watchdog reset flag set by watchdog overflow, cleared by pin or write
// - Output enable lets a watchdog reset drive reset output pin low, else pin released
// - Word write key 5a loads counter, key a5 loads control
// - Word write a5 00 to reset control clears watchdog reset flag
// - Word write key 5a to reset control copies output enable bit
// - Byte reads return control, counter, reset control at three addresses
// - Watchdog overflow resets chip; interval overflow raises interrupt
// - Internal reset held 518 cycles, output pin driven 132 cycles
// - Watchdog reset clears overflow flag but keeps watchdog reset flag
// - Counter write wins over a coincident count pulse
// - Simultaneous pin reset and watchdog reset act as pin reset
module watchdog_interval_timer #(
    parameter int CHIP_RESET_CYCLES = wdt_pkg::CHIP_RESET_STATES,
    parameter int PIN_RESET_CYCLES = wdt_pkg::PIN_RESET_STATES
) (
    // Clock and external init pin reset
    input wire logic CLK,
    input wire logic RSTN,
    // Standby entry
    input wire logic STANDBY,
    // CPU register port
    input wire logic [15:0] ADDR,
    input wire logic WR,
    input wire logic WORD,
    input wire logic [15:0] WDATA,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Events
    output logic INTERVAL_IRQ,
    output logic CHIP_RESET_N,
    // Reset output pin, open drain
    output logic RESET_OUT_O,
    output logic RESET_OUT_OE
);
    logic [7:0] counter_reg;
    logic ovf_reg;
    logic mode_reg;
    logic run_reg;
    logic [2:0] cks_reg;
    logic wd_reset_flag_reg;
    logic reset_out_enable_reg;
    logic ovf_seen_reg;
    logic [9:0] chip_cnt_reg;
    logic [9:0] pin_cnt_reg;
    logic [7:0] rdata_next;
    logic tick;
    logic wr_word;
    logic wr_cnt;
    logic wr_cs;
    logic wr_rc_clr;
    logic wr_rc_oe;
    logic overflow;
    logic wd_fire;
    logic int_rst;
    logic rd_cs;
    logic [9:0] rst_len_reg;

    wdt_prescaler #(.WIDTH(wdt_pkg::PRESCALE_WIDTH)) u_prescaler (
        .clk(CLK),
        .rst_n(RSTN),
        .sel(cks_reg),
        .tick(tick)
    );

    assign wr_word = WR && WORD;
    // Key selects target, other keys dropped
    assign wr_cs = wr_word && ADDR == wdt_pkg::ADDR_CS_WR
        && WDATA[15:8] == wdt_pkg::KEY_CONTROL;
    assign wr_cnt = wr_word && ADDR == wdt_pkg::ADDR_CS_WR
        && WDATA[15:8] == wdt_pkg::KEY_COUNTER;
    assign wr_rc_clr = wr_word && ADDR == wdt_pkg::ADDR_RC_WR
        && WDATA[15:8] == wdt_pkg::KEY_CONTROL && WDATA[7:0] == 8'h00;
    assign wr_rc_oe = wr_word && ADDR == wdt_pkg::ADDR_RC_WR
        && WDATA[15:8] == wdt_pkg::KEY_COUNTER;
    assign rd_cs = RD && ADDR == wdt_pkg::ADDR_CS_RD;

    assign overflow = run_reg && tick && !wr_cnt && counter_reg == 8'hff;
    // Mode bit picks reset or interrupt
    // Watchdog fires, pin reset wins via RSTN priority
    assign wd_fire = overflow && mode_reg;
    assign int_rst = chip_cnt_reg != 10'h000;

    always_ff @(posedge CLK) begin
        if (!RSTN || int_rst || STANDBY) begin
            counter_reg <= wdt_pkg::CNT_RESET;
        end else if (wr_cnt) begin
            counter_reg <= WDATA[7:0];
        end else if (!run_reg) begin
            counter_reg <= wdt_pkg::CNT_RESET;
        end else if (tick) begin
            counter_reg <= counter_reg + 8'h01;
        end
    end

    // Upper bits clear in standby, cleared by internal reset
    always_ff @(posedge CLK) begin
        if (!RSTN || int_rst || STANDBY) begin
            mode_reg <= 1'b0;
            run_reg <= 1'b0;
        end else if (wr_cs) begin
            mode_reg <= WDATA[wdt_pkg::CS_MODE_BIT];
            run_reg <= WDATA[wdt_pkg::CS_RUN_BIT];
        end
    end

    // Set wins, clear needs prior read as one
    always_ff @(posedge CLK) begin
        if (!RSTN || int_rst || STANDBY) begin
            ovf_reg <= 1'b0;
            ovf_seen_reg <= 1'b0;
        end else if (overflow) begin
            ovf_reg <= 1'b1;
        end else begin
            if (rd_cs && ovf_reg) begin
                ovf_seen_reg <= 1'b1;
            end
            if (wr_cs && ovf_seen_reg && !WDATA[wdt_pkg::CS_OVF_BIT]) begin
                ovf_reg <= 1'b0;
                ovf_seen_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN || int_rst) begin
            cks_reg <= 3'h0;
        end else if (wr_cs) begin
            cks_reg <= WDATA[wdt_pkg::CS_CKS_LSB +: 3];
        end
    end

    // Only the pin reset initialises these; set wins over clear
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            wd_reset_flag_reg <= 1'b0;
            reset_out_enable_reg <= 1'b0;
        end else begin
            if (wd_fire) begin
                wd_reset_flag_reg <= 1'b1;
            end else if (wr_rc_clr) begin
                wd_reset_flag_reg <= 1'b0;
            end
            if (wr_rc_oe) begin
                reset_out_enable_reg <= WDATA[wdt_pkg::RC_RESET_OUT_ENABLE_BIT];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            chip_cnt_reg <= 10'h000;
            pin_cnt_reg <= 10'h000;
        end else if (wd_fire) begin
            chip_cnt_reg <= 10'(CHIP_RESET_CYCLES);
            pin_cnt_reg <= reset_out_enable_reg ? 10'(PIN_RESET_CYCLES) : 10'h000;
        end else begin
            if (chip_cnt_reg != 10'h000) begin
                chip_cnt_reg <= chip_cnt_reg - 10'h001;
            end
            if (pin_cnt_reg != 10'h000) begin
                pin_cnt_reg <= pin_cnt_reg - 10'h001;
            end
        end
    end

    // Read mux, reserved bits as ones
    always_comb begin
        unique case (ADDR)
            wdt_pkg::ADDR_CS_RD: rdata_next = {ovf_reg, mode_reg, run_reg,
                2'b11, cks_reg} | wdt_pkg::CS_RSVD_MASK;
            wdt_pkg::ADDR_CNT_RD: rdata_next = counter_reg;
            wdt_pkg::ADDR_RC_RD: rdata_next = {wd_reset_flag_reg, reset_out_enable_reg, 6'h00}
                | wdt_pkg::RC_RSVD_MASK;
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            RDATA <= rdata_next;
        end
    end

    // Interval request follows the flag in interval mode
    assign INTERVAL_IRQ = ovf_reg && !mode_reg;
    assign CHIP_RESET_N = !int_rst;
    // Open-drain low while enabled pulse runs
    assign RESET_OUT_O = 1'b0;
    assign RESET_OUT_OE = pin_cnt_reg != 10'h000;

    property p_ovf_set;
        @(posedge CLK) disable iff (!RSTN)
        overflow && !int_rst && !STANDBY |=> ovf_reg;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("flag not set");

    property p_halt;
        @(posedge CLK) disable iff (!RSTN)
        !run_reg && !wr_cnt |=> counter_reg == 8'h00;
    endproperty
    a_halt: assert property (p_halt) else $error("counter not halted");

    property p_write_wins;
        @(posedge CLK) disable iff (!RSTN)
        wr_cnt && !int_rst && !STANDBY |=> counter_reg == $past(WDATA[7:0]);
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("write lost");

    property p_wd_reset;
        @(posedge CLK) disable iff (!RSTN)
        wd_fire |=> !CHIP_RESET_N && wd_reset_flag_reg ##1 !ovf_reg;
    endproperty
    a_wd_reset: assert property (p_wd_reset) else $error("no chip reset");

    // Cycles spent in the internal reset, for the length check
    always_ff @(posedge CLK) begin
        if (!RSTN || !int_rst) begin
            rst_len_reg <= 10'h000;
        end else begin
            rst_len_reg <= rst_len_reg + 10'h001;
        end
    end

    property p_chip_len;
        @(posedge CLK) disable iff (!RSTN)
        $fell(int_rst) |-> rst_len_reg == 10'(CHIP_RESET_CYCLES);
    endproperty
    a_chip_len: assert property (p_chip_len) else $error("reset length");

    property p_pin_len;
        @(posedge CLK) disable iff (!RSTN)
        wd_fire && reset_out_enable_reg |=>
            RESET_OUT_OE ##131 RESET_OUT_OE ##1 !RESET_OUT_OE;
    endproperty
    a_pin_len: assert property (p_pin_len) else $error("pin length");

    property p_byte_ignored;
        @(posedge CLK) disable iff (!RSTN)
        WR && !WORD && !overflow && !int_rst && !STANDBY |=>
            $stable(mode_reg) && $stable(run_reg);
    endproperty
    a_byte_ignored: assert property (p_byte_ignored) else $error("byte wr");

    property p_wd_reset_flag_clr;
        @(posedge CLK) disable iff (!RSTN)
        wr_rc_clr && !wd_fire |=> !wd_reset_flag_reg;
    endproperty
    a_wd_reset_flag_clr: assert property (p_wd_reset_flag_clr) else $error("flag kept");

    property p_irq;
        @(posedge CLK) disable iff (!RSTN)
        overflow && !mode_reg && !STANDBY && !int_rst |=> INTERVAL_IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("no interval irq");

    property p_cs_write;
        @(posedge CLK) disable iff (!RSTN)
        wr_cs && !int_rst && !STANDBY |=>
            mode_reg == $past(WDATA[wdt_pkg::CS_MODE_BIT])
            && run_reg == $past(WDATA[wdt_pkg::CS_RUN_BIT]);
    endproperty
    a_cs_write: assert property (p_cs_write) else $error("cs write");

    property p_cks_write;
        @(posedge CLK) disable iff (!RSTN)
        wr_cs && !int_rst |=>
            cks_reg == $past(WDATA[wdt_pkg::CS_CKS_LSB +: 3]);
    endproperty
    a_cks_write: assert property (p_cks_write) else $error("cks write");

    property p_oe_copy;
        @(posedge CLK) disable iff (!RSTN)
        wr_rc_oe |=>
            reset_out_enable_reg == $past(WDATA[wdt_pkg::RC_RESET_OUT_ENABLE_BIT]);
    endproperty
    a_oe_copy: assert property (p_oe_copy) else $error("oe copy");

    property p_bad_key;
        @(posedge CLK) disable iff (!RSTN)
        wr_word && WDATA[15:8] != wdt_pkg::KEY_COUNTER
            && WDATA[15:8] != wdt_pkg::KEY_CONTROL
            && !overflow && !int_rst && !STANDBY |=>
            $stable(mode_reg) && $stable(run_reg) && $stable(cks_reg)
            && $stable(reset_out_enable_reg) && $stable(wd_reset_flag_reg) && $stable(ovf_reg);
    endproperty
    a_bad_key: assert property (p_bad_key) else $error("bad key");

    property p_stby;
        @(posedge CLK) disable iff (!RSTN)
        STANDBY && !wr_cs && !int_rst |=> !mode_reg && !run_reg
            && !ovf_reg && counter_reg == 8'h00 && $stable(cks_reg);
    endproperty
    a_stby: assert property (p_stby) else $error("standby clear");

    property p_rd_cs_rsvd;
        @(posedge CLK) disable iff (!RSTN)
        RD && ADDR == wdt_pkg::ADDR_CS_RD |=>
            (RDATA & wdt_pkg::CS_RSVD_MASK) == wdt_pkg::CS_RSVD_MASK;
    endproperty
    a_rd_cs_rsvd: assert property (p_rd_cs_rsvd) else $error("cs rsvd");

    property p_rd_rc_rsvd;
        @(posedge CLK) disable iff (!RSTN)
        RD && ADDR == wdt_pkg::ADDR_RC_RD |=>
            (RDATA & wdt_pkg::RC_RSVD_MASK) == wdt_pkg::RC_RSVD_MASK;
    endproperty
    a_rd_rc_rsvd: assert property (p_rd_rc_rsvd) else $error("rc rsvd");

    property p_rd_cnt;
        @(posedge CLK) disable iff (!RSTN)
        RD && ADDR == wdt_pkg::ADDR_CNT_RD |=> RDATA == $past(counter_reg);
    endproperty
    a_rd_cnt: assert property (p_rd_cnt) else $error("cnt read");

    property p_pin_init;
        @(posedge CLK)
        !RSTN |=> !wd_reset_flag_reg && !reset_out_enable_reg;
    endproperty
    a_pin_init: assert property (p_pin_init) else $error("pin init");

    property p_pin_wins;
        @(posedge CLK)
        !RSTN |=> CHIP_RESET_N && !RESET_OUT_OE;
    endproperty
    a_pin_wins: assert property (p_pin_wins) else $error("pin wins");

    c_wd: cover property (@(posedge CLK) disable iff (!RSTN) wd_fire);
    c_irq: cover property (@(posedge CLK) disable iff (!RSTN)
        overflow && !mode_reg);
    c_pin: cover property (@(posedge CLK) disable iff (!RSTN) RESET_OUT_OE);
    c_stby: cover property (@(posedge CLK) disable iff (!RSTN) STANDBY);
    c_ovf_clr: cover property (@(posedge CLK) disable iff (!RSTN)
        $fell(ovf_reg) && !int_rst);
endmodule : watchdog_interval_timer

// [watchdog_interval_timer_tb_top.sv]
// Self-checking bench for the supervisory timer
module watchdog_interval_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DIV [8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};
    logic clk;
    logic rst_n;
    logic standby;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr, word, rd, irq, chip_rst_n, rst_o, rst_oe;
    logic [7:0] rdata;
    logic [7:0] v;
    int err_total;
    int cmp_count;
    int cyc;
    int n_low;
    int n_oe;
    watchdog_interval_timer DUT (.CLK(clk), .RSTN(rst_n),
        .STANDBY(standby), .ADDR(addr), .WR(wr), .WORD(word),
        .WDATA(wdata), .RD(rd), .RDATA(rdata), .INTERVAL_IRQ(irq),
        .CHIP_RESET_N(chip_rst_n), .RESET_OUT_O(rst_o),
        .RESET_OUT_OE(rst_oe));
    cpu_bus_model cpu (.clk(clk), .addr(addr), .wr(wr), .word(word),
        .wdata(wdata), .rd(rd), .rdata(rdata));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic close_out();
        if (err_total == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic rdchk(input logic [15:0] a, input logic [7:0] e,
                         input string what);
        cpu.get(a, v);
        chk(what, {8'h00, e}, {8'h00, v});
    endtask : rdchk
    // Hang guard, well above the roughly 15k cycles of the run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        rst_n = 1'b0;
        standby = 1'b0;
        err_total = 0;
        cmp_count = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(16'hffa8, wdt_pkg::CS_RESET, "cs");
        rdchk(16'hffa9, 8'h00, "cnt");
        rdchk(16'hffab, wdt_pkg::RC_RESET, "rc");
        rdchk(16'hffaa, 8'h00, "unmapped");
        cpu.put(16'hffa8, 16'ha527, 1'b0);
        cpu.put(16'hffa8, 16'h3327, 1'b1);
        rdchk(16'hffa8, 8'h18, "cs kept");
        cpu.put(16'hffa8, 16'ha5ff, 1'b1);
        rdchk(16'hffa8, 8'h7f, "cs ones");
        cpu.put(16'hffa8, 16'ha520, 1'b1);
        cpu.put(16'hffa8, 16'h5afe, 1'b1);
        for (int i = 0; i < 20 && irq !== 1'b1; i++) @(negedge clk);
        chk("irq", 16'h0001, {15'h0000, irq});
        cpu.put(16'hffa8, 16'ha520, 1'b1);
        rdchk(16'hffa8, 8'hb8, "ovf kept");
        cpu.put(16'hffa8, 16'ha520, 1'b1);
        rdchk(16'hffa8, 8'h38, "ovf clear");
        chk("irq low", 16'h0000, {15'h0000, irq});
        cpu.put(16'hffa8, 16'ha500, 1'b1);
        rdchk(16'hffa9, 8'h00, "cnt stop");
        // two ticks per two tap periods
        foreach (DIV[k]) begin
            cpu.put(16'hffa8, {8'ha5, 8'h00 + 8'(k)}, 1'b1);
            cpu.put(16'hffa8, {8'ha5, 8'h20 + 8'(k)}, 1'b1);
            repeat (2 * DIV[k] - 1) @(posedge clk);
            rdchk(16'hffa9, 8'h02, "tap count");
            cpu.put(16'hffa8, 16'ha500, 1'b1);
        end
        cpu.put(16'hffa8, 16'ha527, 1'b1);
        @(posedge clk);
        standby <= 1'b1;
        @(posedge clk);
        standby <= 1'b0;
        rdchk(16'hffa8, 8'h1f, "standby");
        cpu.put(16'hffaa, 16'h5a40, 1'b1);
        rdchk(16'hffab, 8'h7f, "oe set");
        cpu.put(16'hffa8, 16'ha560, 1'b1);
        cpu.put(16'hffa8, 16'h5afe, 1'b1);
        n_low = 0;
        n_oe = 0;
        for (int i = 0; i < 700; i++) begin
            @(negedge clk);
            n_low += int'(chip_rst_n === 1'b0);
            n_oe += int'(rst_oe === 1'b1 && rst_o === 1'b0);
        end
        chk("chip rst", 16'(wdt_pkg::CHIP_RESET_STATES), 16'(n_low));
        chk("pin rst", 16'(wdt_pkg::PIN_RESET_STATES), 16'(n_oe));
        rdchk(16'hffab, 8'hff, "wd flag");
        rdchk(16'hffa8, 8'h18, "cs after");
        cpu.put(16'hffaa, 16'ha500, 1'b1);
        rdchk(16'hffab, 8'h7f, "flag clr");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(16'hffab, 8'h3f, "pin reset");
        close_out();
    end
endmodule : watchdog_interval_timer_tb_top

// [wdt_pkg.sv]
// Package: register map, field layout and timing of the supervisory timer
package wdt_pkg;
    localparam logic [15:0] ADDR_CS_WR = 16'hffa8;
    localparam logic [15:0] ADDR_CS_RD = 16'hffa8;
    localparam logic [15:0] ADDR_CNT_RD = 16'hffa9;
    localparam logic [15:0] ADDR_RC_WR = 16'hffaa;
    localparam logic [15:0] ADDR_RC_RD = 16'hffab;
    localparam logic [7:0] KEY_COUNTER = 8'h5a;
    localparam logic [7:0] KEY_CONTROL = 8'ha5;
    localparam logic [7:0] CS_RESET = 8'h18;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] RC_RESET = 8'h3f;
    localparam logic [7:0] CS_RSVD_MASK = 8'h18;
    localparam logic [7:0] RC_RSVD_MASK = 8'h3f;
    localparam int CS_OVF_BIT = 7;
    localparam int CS_MODE_BIT = 6;
    localparam int CS_RUN_BIT = 5;
    localparam int CS_CKS_LSB = 0;
    localparam int RC_WD_RESET_FLAG_BIT = 7;
    localparam int RC_RESET_OUT_ENABLE_BIT = 6;
    localparam int CHIP_RESET_STATES = 518;
    localparam int PIN_RESET_STATES = 132;
    localparam int PRESCALE_WIDTH = 12;
endpackage : wdt_pkg

// [wdt_prescaler.sv]
// Prescaler: free-running divider giving one-cycle taps of the clock
module wdt_prescaler #(
    parameter int WIDTH = wdt_pkg::PRESCALE_WIDTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Tap select and enable pulse
    input wire logic [2:0] sel,
    output logic tick
);
    logic [WIDTH-1:0] div_reg;
    logic [WIDTH-1:0] div_next;

    function automatic int tap_of(input logic [2:0] s);
        case (s)
            3'h0: tap_of = 1;
            3'h1: tap_of = 5;
            3'h2: tap_of = 6;
            3'h3: tap_of = 7;
            3'h4: tap_of = 8;
            3'h5: tap_of = 9;
            3'h6: tap_of = 11;
            default: tap_of = 12;
        endcase
    endfunction : tap_of

    assign div_next = div_reg + {{(WIDTH-1){1'b0}}, 1'b1};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    // Pulse when the low bits wrap: one per 2^tap cycles
    always_comb begin
        tick = 1'b1;
        for (int i = 0; i < WIDTH; i++) begin
            if (i < tap_of(sel) && div_reg[i] == 1'b0) begin
                tick = 1'b0;
            end
        end
    end
endmodule : wdt_prescaler
